/* File: rtl/dcls_defs.vh */
// Purpose: constants for the debug clock / led share control block
// Assumes: 25 MHz system clock
// Notes: offsets and fields of the debug control register
`ifndef DCLS_DEFS_VH
`define DCLS_DEFS_VH
`define DCLS_CTRL_ADDR 8'h03
`define DCLS_SFR_BASE 8'h80
`define DCLS_BIT_FWR 0
`define DCLS_BIT_FRD 1
`define DCLS_BIT_STOP 2
`define DCLS_BIT_NOPULSE 3
`define DCLS_BIT_LEDDIS 4
`define DCLS_BIT_BUSY 5
`define DCLS_CTRL_RESET 8'h00
`define DCLS_WMASK 8'h1f
`define DCLS_CLK_MHZ 25
`define DCLS_ACK_NS 1000
`define DCLS_ACK_CYC ((`DCLS_ACK_NS * `DCLS_CLK_MHZ + 999) / 1000)
`define DCLS_FP_CYC 6
`endif

/* File: rtl/dcls_share_ctrl.v */
// Purpose: debug clock pin sharing with the led driver, debug control reg
// Assumes: debug master owns pin clock; reg access from debug fsm in clk_i
// Notes: fast path completes in a fixed window, busy shown in bit 5
`timescale 1ns/1ps
`include "dcls_defs.vh"
module dcls_share_ctrl
(
  input wire clk_i,
  input wire reset_n_i,
  // debug clock pin, three signals, oe low while driving
  input wire dbg_clk_pin_i,
  output wire dbg_clk_pin_o,
  output wire dbg_clk_pin_oe_n_o,
  // led driver request from application logic
  input wire led_data_i,
  output wire led_drive_o,
  // mode inputs
  input wire debug_enable_i,
  input wire pin_clock_as_system_i,
  input wire scan_mode_i,
  input wire dsr_active_i,
  input wire dsr_patch_i,
  // halt acknowledge request from the debug service routine
  input wire halt_ack_req_i,
  output wire halt_ack_done_o,
  // debug fsm register access, same clock
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  // debug transaction marker and data pin steal
  input wire dbg_txn_i,
  output wire data_pin_steal_o,
  // fast path sfr side
  output wire sfr_wr_o,
  output wire sfr_rd_o,
  output wire [7:0] sfr_addr_o,
  output wire [7:0] sfr_wdata_o,
  input wire [7:0] sfr_rdata_i,
  output wire fast_path_pending_o,
  // cpu stop
  input wire cpu_stop_req_i,
  output wire cpu_stop_sync_o,
  output wire cpu_stop_immediate_o,
  output wire debug_fsm_hold_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_PULSE = 2'd1;
  localparam ST_DONE = 2'd2;
  localparam integer ACK_CYC_I = `DCLS_ACK_CYC;
  localparam integer FP_CYC_I = `DCLS_FP_CYC;
  // counts are cut to their counter widths on purpose
  localparam [4:0] ACK_CYC = ACK_CYC_I[4:0];
  localparam [2:0] FP_CYC = FP_CYC_I[2:0];

  wire pin_s;
  reg [7:0] ctrl_q;
  reg [1:0] ack_st_q;
  reg [4:0] ack_cnt_q;
  reg [2:0] fp_cnt_q;
  reg [7:0] rdata_q;
  reg [7:0] sfr_addr_q;
  reg [7:0] sfr_wdata_q;
  reg sfr_wr_q;
  reg sfr_rd_q;
  reg led_q;
  reg hold_q;
  reg steal_q;
  reg stop_sync_q;

  wire fast_wr;
  wire fast_rd;
  wire led_block;
  wire led_active;

  // pin level is sampled only through the synchroniser
  dcls_sync2 u_pin_sync
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .d_i(dbg_clk_pin_i),
    .q_o(pin_s)
  );

  // one gating term over every blocking cause
  assign led_block = ctrl_q[`DCLS_BIT_LEDDIS]
    | (dsr_active_i & ~dsr_patch_i)
    | pin_clock_as_system_i
    | scan_mode_i;
  assign led_active = led_data_i & ~led_block;

  assign fast_wr = reg_wr_i & ctrl_q[`DCLS_BIT_FWR]
    & (reg_addr_i >= `DCLS_SFR_BASE);
  assign fast_rd = reg_rd_i & ctrl_q[`DCLS_BIT_FRD]
    & (reg_addr_i >= `DCLS_SFR_BASE);

  // control register; led disable stays until written low or reset
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      ctrl_q <= `DCLS_CTRL_RESET;
    else if (reg_wr_i && reg_addr_i == `DCLS_CTRL_ADDR)
      ctrl_q <= reg_wdata_i & `DCLS_WMASK;
  end

  // fast path: issue one sfr access, count out the service window
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      fp_cnt_q <= 3'h0;
      sfr_wr_q <= 1'b0;
      sfr_rd_q <= 1'b0;
      sfr_addr_q <= 8'h00;
      sfr_wdata_q <= 8'h00;
    end
    else
    begin
      sfr_wr_q <= fast_wr;
      sfr_rd_q <= fast_rd;
      if (fast_wr || fast_rd)
      begin
        sfr_addr_q <= reg_addr_i;
        sfr_wdata_q <= reg_wdata_i;
        fp_cnt_q <= FP_CYC - 3'h1;
      end
      else if (fp_cnt_q != 3'h0)
        fp_cnt_q <= fp_cnt_q - 3'h1;
    end
  end

  // read data: fast reads take sfr data one cycle after the sfr read strobe
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      rdata_q <= 8'h00;
    else if (reg_rd_i && reg_addr_i == `DCLS_CTRL_ADDR)
      rdata_q <= {2'b00, (fp_cnt_q != 3'h0), ctrl_q[4:0]};
    else if (sfr_rd_q)
      rdata_q <= sfr_rdata_i;
  end

  // halt acknowledge: low pulse on the pin or an immediate ack
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      ack_st_q <= ST_IDLE;
      ack_cnt_q <= 5'h00;
    end
    else
    begin
      case (ack_st_q)
        ST_IDLE:
        begin
          if (halt_ack_req_i)
          begin
            if (ctrl_q[`DCLS_BIT_NOPULSE])
              ack_st_q <= ST_DONE;
            else
            begin
              ack_st_q <= ST_PULSE;
              ack_cnt_q <= ACK_CYC;
            end
          end
        end
        ST_PULSE:
        begin
          if (ack_cnt_q == 5'h01)
            ack_st_q <= ST_DONE;
          ack_cnt_q <= ack_cnt_q - 5'h01;
        end
        ST_DONE:
        begin
          if (!halt_ack_req_i)
            ack_st_q <= ST_IDLE;
        end
        default:
          ack_st_q <= ST_IDLE;
      endcase
    end
  end

  // led, fsm hold, data pin steal, cpu stop
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      led_q <= 1'b0;
      hold_q <= 1'b1;
      steal_q <= 1'b0;
      stop_sync_q <= 1'b0;
    end
    else
    begin
      led_q <= led_active;
      hold_q <= led_active | ~debug_enable_i;
      if (dbg_txn_i && !hold_q)
        steal_q <= 1'b1;
      else if (hold_q)
        steal_q <= 1'b0;
      // synchronous stop is taken only while the synchronised pin level stands high,
      // which lags the pin by two cycles, so it can land early in a low link phase
      stop_sync_q <= cpu_stop_req_i & ~ctrl_q[`DCLS_BIT_STOP]
        & (stop_sync_q | pin_s);
    end
  end

  // pin is driven low during the pulse, else led drives, else released
  assign dbg_clk_pin_o = (ack_st_q == ST_PULSE) ? 1'b0 : led_q;
  assign dbg_clk_pin_oe_n_o = ~((ack_st_q == ST_PULSE) | led_q);
  assign led_drive_o = led_q;
  assign halt_ack_done_o = (ack_st_q == ST_DONE);
  assign reg_rdata_o = rdata_q;
  assign data_pin_steal_o = steal_q;
  assign sfr_wr_o = sfr_wr_q;
  assign sfr_rd_o = sfr_rd_q;
  assign sfr_addr_o = sfr_addr_q;
  assign sfr_wdata_o = sfr_wdata_q;
  assign fast_path_pending_o = (fp_cnt_q != 3'h0);
  assign cpu_stop_sync_o = stop_sync_q;
  assign cpu_stop_immediate_o = cpu_stop_req_i
    & ctrl_q[`DCLS_BIT_STOP];
  assign debug_fsm_hold_o = hold_q;
endmodule

/* File: rtl/dcls_sync2.v */
// Purpose: two flip-flop synchroniser for one level
// Assumes: input is asynchronous to clk_i
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module dcls_sync2
(
  input wire clk_i,
  input wire reset_n_i,
  input wire d_i,
  output wire q_o
);
  reg meta_q;
  reg sync_q;
  // plain double register, reset to low
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule

/* File: test/dcls_link_master.sv */
// Purpose: debug master clock driven onto the shared pin
// Assumes: 320 ns link period
// Notes: clock stands still high outside frames
`timescale 1ns/1ps
module dcls_link_master
(
  input wire run_i,
  input wire stretch_i,
  output logic clk_o
);
  // stretched low phase leaves the device six system clocks to fetch
  initial clk_o = 1'h1;
  always
  begin
    wait (run_i);
    #160 clk_o = 1'h0;
    #(stretch_i ? 240 : 160) clk_o = 1'h1;
  end
endmodule

/* File: test/dcls_share_ctrl_bench.sv */
// Purpose: self-checking bench for the share control block
// Assumes: 25 MHz clock, link clock 320 ns
// Notes: one task per scenario
`timescale 1ns/1ps
module dcls_share_ctrl_bench;
  logic clk_i = 1'h0, reset_n_i = 1'h0, led_data_i = 1'h0, run = 1'h0;
  logic pin_clock_as_system_i = 1'h0, scan_mode_i = 1'h0, stretch = 1'h0;
  logic dsr_active_i = 1'h0, dsr_patch_i = 1'h0, halt_ack_req_i = 1'h0;
  logic reg_wr_i = 1'h0, reg_rd_i = 1'h0, debug_enable_i = 1'h1;
  logic dbg_txn_i = 1'h0, cpu_stop_req_i = 1'h0, mclk;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, sfr_rdata_i = 8'h5c;
  logic dbg_clk_pin_i, dbg_clk_pin_o, dbg_clk_pin_oe_n_o, led_drive_o;
  logic halt_ack_done_o, data_pin_steal_o, sfr_wr_o, sfr_rd_o;
  logic fast_path_pending_o, cpu_stop_sync_o, cpu_stop_immediate_o;
  logic debug_fsm_hold_o;
  logic [7:0] reg_rdata_o, sfr_addr_o, sfr_wdata_o;
  int error_cnt = 0, cmp_count = 0;
  always #20 clk_i = ~clk_i;
  // the pin carries the device level only while its enable is low
  assign dbg_clk_pin_i = dbg_clk_pin_oe_n_o ? mclk : dbg_clk_pin_o;
  dcls_link_master mst_u (.run_i(run), .stretch_i(stretch), .clk_o(mclk));
  dcls_share_ctrl dut_u (.*);
  task cmp(input [15:0] s, input [15:0] e);
  begin
    cmp_count++;
    if (s !== e)
      $display("Error %0t seen %h expected %h", $time, s, e);
    if (s !== e)
      error_cnt++;
  end
  endtask
  task tick(input int n);
  begin
    repeat (n) @(posedge clk_i);
    #1;
  end
  endtask
  // one register access; strobes change only at a rising edge, one cycle
  // wide; writes return just after the taking edge, reads one edge later
  task acc(input w, input [7:0] a, input [7:0] d);
  begin
    @(posedge clk_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'h0;
    reg_rd_i <= 1'h0;
    #1;
    if (!w)
      tick(1);
  end
  endtask
  task gate(input [3:0] m, input [7:0] e);
  begin
    @(posedge clk_i);
    {scan_mode_i, pin_clock_as_system_i, dsr_active_i, dsr_patch_i} <= m;
    tick(2);
    cmp(led_drive_o, e);
  end
  endtask
  task t_led;
  begin
    acc(1'h0, 8'h03, 8'h00);
    cmp(reg_rdata_o, 8'h00);
    cmp(debug_fsm_hold_o, 8'h00);
    @(posedge clk_i);
    led_data_i <= 1'h1;
    gate(4'h0, 8'h01);
    cmp(debug_fsm_hold_o, 8'h01);
    acc(1'h1, 8'h03, 8'hff);
    gate(4'h0, 8'h00);
    acc(1'h1, 8'h10, 8'h00);
    gate(4'h0, 8'h00);
    acc(1'h1, 8'h03, 8'h00);
    gate(4'h0, 8'h01);
    gate(4'h8, 8'h00);
    gate(4'h4, 8'h00);
    gate(4'h2, 8'h00);
    gate(4'h3, 8'h01);
    @(posedge clk_i);
    led_data_i <= 1'h0;
    gate(4'h0, 8'h00);
    cmp(debug_fsm_hold_o, 8'h00);
    // a disabled interface stays held even with the led released
    @(posedge clk_i);
    debug_enable_i <= 1'h0;
    tick(2);
    cmp(debug_fsm_hold_o, 8'h01);
    @(posedge clk_i);
    debug_enable_i <= 1'h1;
    tick(2);
    cmp(debug_fsm_hold_o, 8'h00);
  end
  endtask
  task t_fast;
  begin
    @(posedge clk_i);
    run <= 1'h1;
    dbg_txn_i <= 1'h1;
    acc(1'h1, 8'h03, 8'h07);
    cmp(data_pin_steal_o, 8'h01);
    acc(1'h1, 8'h90, 8'ha5);
    cmp({sfr_wr_o, sfr_addr_o}, 16'h0190);
    cmp(sfr_wdata_o, 8'ha5);
    acc(1'h0, 8'h03, 8'h00);
    cmp(reg_rdata_o, 8'h27);
    @(posedge clk_i);
    cpu_stop_req_i <= 1'h1;
    tick(6);
    cmp({cpu_stop_immediate_o, cpu_stop_sync_o}, 8'h02);
    @(posedge clk_i);
    stretch <= 1'h1;
    acc(1'h0, 8'h85, 8'h00);
    cmp(reg_rdata_o, 8'h5c);
    acc(1'h1, 8'h03, 8'h00);
    // the synchronous stop waits for the pin clock to stand high
    tick(10);
    cmp({cpu_stop_immediate_o, cpu_stop_sync_o}, 8'h01);
    @(posedge clk_i);
    {run, stretch, dbg_txn_i, cpu_stop_req_i} <= 4'h0;
  end
  endtask
  task t_halt;
    int n;
  begin
    n = 0;
    @(posedge clk_i);
    halt_ack_req_i <= 1'h1;
    repeat (40)
    begin
      tick(1);
      n += !dbg_clk_pin_oe_n_o && !dbg_clk_pin_o;
    end
    cmp(n[7:0], 8'd25);
    cmp(halt_ack_done_o, 8'h01);
    @(posedge clk_i);
    halt_ack_req_i <= 1'h0;
    acc(1'h1, 8'h03, 8'h08);
    @(posedge clk_i);
    halt_ack_req_i <= 1'h1;
    tick(2);
    cmp({dbg_clk_pin_oe_n_o, halt_ack_done_o}, 8'h03);
    // with no pulse the master learns the state by polling a register
    acc(1'h0, 8'h03, 8'h00);
    cmp(reg_rdata_o, 8'h08);
  end
  endtask
  task wrap_up;
  begin
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // the run needs under 500 cycles; this cuts a hang short
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up;
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'h1;
    tick(2);
    t_led;
    t_fast;
    t_halt;
    wrap_up;
  end
endmodule

/* File: test/dcls_share_ctrl_properties.sv */
// Purpose: port assertions for the share control block
// Assumes: one clock, synchronous active low reset
// Notes: bound into every instance of the block
`timescale 1ns/1ps
module dcls_checker
(
  input wire clk_i,
  input wire reset_n_i,
  input wire led_data_i,
  input wire scan_mode_i,
  input wire pin_clock_as_system_i,
  input wire led_drive_o,
  input wire debug_enable_i,
  input wire debug_fsm_hold_o,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire sfr_wr_o,
  input wire sfr_rd_o,
  input wire fast_path_pending_o,
  input wire halt_ack_req_i,
  input wire halt_ack_done_o,
  input wire cpu_stop_req_i,
  input wire cpu_stop_immediate_o
);
  // single domain, so clock and reset are stated once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_led_gate: assert property (led_drive_o |-> $past(led_data_i &
    ~scan_mode_i & ~pin_clock_as_system_i)) else $error("led not gated");
  a_hold_release: assert property ($fell(debug_fsm_hold_o) |->
    $past(debug_enable_i)) else $error("hold released while disabled");
  a_fast_write: assert property (sfr_wr_o |->
    $past(reg_wr_i & reg_addr_i[7])) else $error("stray sfr write");
  a_fast_read: assert property (sfr_rd_o |->
    $past(reg_rd_i & reg_addr_i[7])) else $error("stray sfr read");
  a_pending_span: assert property (sfr_wr_o |-> fast_path_pending_o[*5]
    ##1 !fast_path_pending_o) else $error("busy span wrong");
  a_wr_single: assert property (sfr_wr_o |=> !sfr_wr_o)
    else $error("sfr write not one cycle");
  a_done_req: assert property (halt_ack_done_o |->
    $past(halt_ack_req_i)) else $error("ack without request");
  a_stop_now: assert property (cpu_stop_immediate_o |->
    cpu_stop_req_i) else $error("immediate stop without request");
  c_fast_wr: cover property (sfr_wr_o);
  c_fast_rd: cover property (sfr_rd_o);
  c_halt_done: cover property (halt_ack_done_o);
endmodule
bind dcls_share_ctrl dcls_checker chk_u (.*);
